// file: src/core_supply_pkg.sv
/*
  shared constants and carrier types for the core supply sequencer.
  assumes a 200 MHz mclk and a single clock domain.
*/
`default_nettype none
package core_supply_pkg;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int OC_DELAY_NS = 400;
  localparam int OC_DELAY_CYC = (OC_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] OC_DELAY_CNT = 8'(OC_DELAY_CYC);

  // -----------------------------------------------------------------
  // setpoint table, millivolts
  // -----------------------------------------------------------------
  localparam logic [11:0] HIGH_BAND_TOP_MV = 12'h7d0;  // 2.000 V
  localparam logic [11:0] HIGH_BAND_STEP_MV = 12'h032; // 50 mV
  localparam logic [11:0] LOW_BAND_TOP_MV = 12'h4fb;   // 1.275 V
  localparam logic [11:0] LOW_BAND_STEP_MV = 12'h019;  // 25 mV
  localparam logic [3:0] SHUTDOWN_LOW_BITS = 4'hf;     // 01111 and 11111

  // -----------------------------------------------------------------
  // register port
  // -----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [7:0] SLEW_OFFSET = 8'h04;
  localparam logic [7:0] REF_OFFSET = 8'h08;
  localparam logic [15:0] SLEW_RESET = 16'h00c8;  // one mV per microsecond

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_POR = 6'b000001,
    ST_IDLE = 6'b000010,
    ST_SOFT = 6'b000100,
    ST_RUN = 6'b001000,
    ST_OV_DISCHARGE = 6'b010000,
    ST_FAULT = 6'b100000
  } seq_state_t;

  // pin-level inputs, synchronised as a group
  typedef struct packed {
    logic [4:0] voltage_select_code;
    logic turn_on_input;
    logic vcc_above_lockout;
    logic vin_above_lockout;
    logic oc_phase1;
    logic oc_phase3;
    logic over_voltage;
    logic below_085;
    logic under_voltage;
    logic output_good_flag;
  } pins_t;

  // gate drive permissions
  typedef struct packed {
    logic osc_run;
    logic phase12_enable;
    logic phase3_enable;
    logic low_side_discharge;
  } drive_t;
endpackage
`default_nettype wire

// file: src/core_supply_vid_fault_sequencer.sv
/*
  voltage code decode, reference ramp, power-up sequencing and fault
  latching for a biphase core supply with a fast third phase.
  assumes comparator and pin levels arrive asynchronously, the phase one
  low-side gate state comes from modulator logic on mclk, and software
  reaches the registers over a plain strobe port.
*/
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module core_supply_vid_fault_sequencer
  import core_supply_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pins and comparators
  input wire core_supply_pkg::pins_t pins_async,
  // phase one low-side gate state from the modulator
  input wire logic ph1_low_on,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // regulator control
  output logic [11:0] reference_ramp_node,
  output core_supply_pkg::drive_t drive,
  output logic current_limit_latched,
  output logic undervoltage_armed
);
  import core_supply_pkg::*;

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    pins_t sync1;
    pins_t sync2;
    seq_state_t st;
    logic [11:0] ref_mv;
    logic [15:0] slew_cnt;
    logic [15:0] slew;
    logic [7:0] ph1_on_cnt;
    logic [1:0][7:0] oc_cnt;
    logic oc_latch;
    logic en_seen_low;
    logic uv_armed;
    logic [15:0] rdata;
  } state_t;

  state_t cur_ff;
  state_t nxt_cur;

  pins_t p;
  logic supplies_ok;
  logic shutdown_code;
  logic [11:0] target_mv;
  logic ramping_up;
  logic [1:0] oc_raw;
  logic oc_trip;
  logic [15:0] status_word;

  assign p = cur_ff.sync2;

  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  // codes map linearly within each band; shutdown drives the target to zero
  always_comb begin
    supplies_ok = p.vcc_above_lockout & p.vin_above_lockout;
    shutdown_code = (p.voltage_select_code[3:0] == SHUTDOWN_LOW_BITS);
    if (shutdown_code) begin
      target_mv = 12'h000;
    end else if (!p.voltage_select_code[4]) begin
      target_mv = 12'(HIGH_BAND_TOP_MV - HIGH_BAND_STEP_MV * {8'h00, p.voltage_select_code[3:0]});
    end else begin
      target_mv = 12'(LOW_BAND_TOP_MV - LOW_BAND_STEP_MV * {8'h00, p.voltage_select_code[3:0]});
    end
    ramping_up = (cur_ff.st == ST_RUN) && (cur_ff.ref_mv < target_mv);
    // phase one sense only counts once the low side has been on long enough
    oc_raw[0] = p.oc_phase1 && (cur_ff.ph1_on_cnt >= OC_DELAY_CNT);
    oc_raw[1] = p.oc_phase3;
    oc_trip = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (cur_ff.oc_cnt[i] >= OC_DELAY_CNT && !ramping_up) begin
        oc_trip = 1'b1;
      end
    end
    status_word = {7'h00, cur_ff.uv_armed, cur_ff.oc_latch, shutdown_code, 1'b0, cur_ff.st[4:0]};
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    // two-stage synchroniser, stage one read only by stage two
    nxt_cur.sync1 = pins_async;
    nxt_cur.sync2 = cur_ff.sync1;

    // low-side on-time counter, saturating
    if (!ph1_low_on) begin
      nxt_cur.ph1_on_cnt = 8'h00;
    end else if (cur_ff.ph1_on_cnt < OC_DELAY_CNT) begin
      nxt_cur.ph1_on_cnt = 8'(cur_ff.ph1_on_cnt + 8'h01);
    end

    // qualification counters restart whenever the condition drops
    for (int i = 0; i < 2; i++) begin
      if (!oc_raw[i] || ramping_up || !(cur_ff.st inside {ST_SOFT, ST_RUN})) begin
        nxt_cur.oc_cnt[i] = 8'h00;
      end else if (cur_ff.oc_cnt[i] < OC_DELAY_CNT) begin
        nxt_cur.oc_cnt[i] = 8'(cur_ff.oc_cnt[i] + 8'h01);
      end
    end

    // reference moves one mV per slew interval while regulating, and clears to zero in every other state
    if (cur_ff.st inside {ST_SOFT, ST_RUN}) begin
      if (cur_ff.ref_mv == target_mv || cur_ff.slew_cnt >= cur_ff.slew) begin
        nxt_cur.slew_cnt = 16'h0000;
      end else begin
        nxt_cur.slew_cnt = 16'(cur_ff.slew_cnt + 16'h0001);
      end
      if (cur_ff.slew_cnt >= cur_ff.slew) begin
        if (cur_ff.ref_mv < target_mv) begin
          nxt_cur.ref_mv = 12'(cur_ff.ref_mv + 12'h001);
        end else if (cur_ff.ref_mv > target_mv) begin
          nxt_cur.ref_mv = 12'(cur_ff.ref_mv - 12'h001);
        end
      end
    end else begin
      nxt_cur.ref_mv = 12'h000;
      nxt_cur.slew_cnt = 16'h0000;
    end

    if (!p.turn_on_input) begin
      nxt_cur.en_seen_low = 1'b1;
    end

    // sequencer
    case (cur_ff.st)
      ST_POR: begin
        if (supplies_ok) begin
          nxt_cur.st = ST_IDLE;
          nxt_cur.oc_latch = 1'b0;
        end
      end
      ST_IDLE: begin
        if (p.turn_on_input && !shutdown_code) begin
          nxt_cur.st = ST_SOFT;
        end
      end
      ST_SOFT, ST_RUN: begin
        if (!p.turn_on_input) begin
          nxt_cur.st = ST_FAULT;
          nxt_cur.en_seen_low = 1'b1;
        end else if (p.over_voltage) begin
          nxt_cur.st = ST_OV_DISCHARGE;
          nxt_cur.en_seen_low = 1'b0;
        end else if (oc_trip) begin
          nxt_cur.st = ST_FAULT;
          nxt_cur.oc_latch = 1'b1;
          nxt_cur.en_seen_low = 1'b0;
        end else if (cur_ff.uv_armed && p.under_voltage) begin
          nxt_cur.st = ST_FAULT;
          nxt_cur.en_seen_low = 1'b0;
        end else if (shutdown_code && cur_ff.ref_mv == 12'h000) begin
          nxt_cur.st = ST_IDLE;
        end else if (cur_ff.st == ST_SOFT && cur_ff.ref_mv == target_mv) begin
          nxt_cur.st = ST_RUN;
        end
      end
      ST_OV_DISCHARGE: begin
        if (p.below_085) begin
          nxt_cur.st = ST_FAULT;
        end
      end
      ST_FAULT: begin
        // a low then high on turn-on, or a supply loss through power-on reset, releases the latched fault
        if (p.turn_on_input && cur_ff.en_seen_low) begin
          nxt_cur.st = ST_IDLE;
          nxt_cur.oc_latch = 1'b0;
        end
      end
      default: begin
        nxt_cur.st = ST_POR;
      end
    endcase

    // supply loss overrides everything and restarts from power-on reset
    if (!supplies_ok) begin
      nxt_cur.st = ST_POR;
    end

    // under-voltage watch arms once at reference with output good
    if (cur_ff.st != ST_RUN) begin
      nxt_cur.uv_armed = 1'b0;
    end else if (cur_ff.ref_mv == target_mv && p.output_good_flag) begin
      nxt_cur.uv_armed = 1'b1;
    end

    // register port: reads answer the cycle after the strobe
    if (reg_wr && reg_addr == SLEW_OFFSET) begin
      nxt_cur.slew = reg_wdata;
    end
    nxt_cur.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        STATUS_OFFSET: nxt_cur.rdata = status_word;
        SLEW_OFFSET: nxt_cur.rdata = cur_ff.slew;
        REF_OFFSET: nxt_cur.rdata = {4'h0, cur_ff.ref_mv};
        default: nxt_cur.rdata = 16'h0000;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_ff <= '{st: ST_POR, slew: SLEW_RESET, default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  // gate permissions follow the state alone, so faults cut drive at once
  always_comb begin
    drive.osc_run = !(cur_ff.st inside {ST_POR});
    drive.phase12_enable = cur_ff.st inside {ST_SOFT, ST_RUN};
    drive.phase3_enable = (cur_ff.st == ST_RUN);
    drive.low_side_discharge = (cur_ff.st == ST_OV_DISCHARGE);
  end
  assign reference_ramp_node = cur_ff.ref_mv;
  assign current_limit_latched = cur_ff.oc_latch;
  assign undervoltage_armed = cur_ff.uv_armed;
  assign reg_rdata = cur_ff.rdata;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  // a qualification counter has run out with no upward ramp masking it
  sequence s_oc_held;
    oc_trip;
  endsequence

  // nothing of higher priority competes with the over-current exit
  sequence s_oc_alone;
    cur_ff.st inside {ST_SOFT, ST_RUN} && p.turn_on_input && !p.over_voltage && supplies_ok;
  endsequence

  // over-voltage seen while regulating, with no higher-priority exit
  sequence s_ov_seen;
    cur_ff.st inside {ST_SOFT, ST_RUN} && p.over_voltage && p.turn_on_input && supplies_ok;
  endsequence

  // discharge clamp: lows of phases one and two on, both phase enables off; the oscillator is not checked
  sequence s_ov_clamp;
    drive.low_side_discharge && !drive.phase3_enable && !drive.phase12_enable;
  endsequence

  // supply loss must stop the oscillator and every gate one edge later
  a_lockout_gates_off: assert property (@(posedge mclk) disable iff (rst)
    !supplies_ok |=> !drive.osc_run && !drive.phase12_enable && !drive.phase3_enable && !drive.low_side_discharge)
    else $error("gates active under supply lockout");

  // the third phase may only come on once soft-start reached its target
  a_soft_no_third: assert property (@(posedge mclk) disable iff (rst)
    $rose(drive.phase3_enable) |-> $past(cur_ff.st) == ST_SOFT && $past(cur_ff.ref_mv == target_mv))
    else $error("third phase on before soft-start ended");

  // modular differences, so either direction of a one mV move passes
  a_ref_no_step: assert property (@(posedge mclk) disable iff (rst)
    $past(cur_ff.st) inside {ST_SOFT, ST_RUN} && cur_ff.st inside {ST_SOFT, ST_RUN}
    |-> (cur_ff.ref_mv - $past(cur_ff.ref_mv) <= 12'h001) || ($past(cur_ff.ref_mv) - cur_ff.ref_mv <= 12'h001))
    else $error("reference stepped");

  // a qualified trip with no competing exit always sets the latch
  a_oc_trip_delay: assert property (@(posedge mclk) disable iff (rst)
    s_oc_held ##0 s_oc_alone |=> current_limit_latched)
    else $error("qualified over-current did not latch");

  // the latch never rises before a counter has run the full delay
  a_oc_needs_time: assert property (@(posedge mclk) disable iff (rst)
    $rose(current_limit_latched) |-> $past(cur_ff.oc_cnt[0]) == OC_DELAY_CNT || $past(cur_ff.oc_cnt[1]) == OC_DELAY_CNT)
    else $error("latch set before qualification delay");

  // a dropped sense restarts its counter, so short glitches never add up
  a_oc_restart: assert property (@(posedge mclk) disable iff (rst)
    (!oc_raw[0] |=> cur_ff.oc_cnt[0] == 8'h00) and (!oc_raw[1] |=> cur_ff.oc_cnt[1] == 8'h00))
    else $error("over-current counter kept counting");

  // low side off: its on-time restarts, so phase one stops counting
  a_ph1_blank: assert property (@(posedge mclk) disable iff (rst)
    !ph1_low_on |=> ##1 cur_ff.oc_cnt[0] == 8'h00)
    else $error("phase one sensed without low-side on-time");

  // latched current limit keeps every phase off
  a_latch_all_off: assert property (@(posedge mclk) disable iff (rst)
    current_limit_latched |-> !drive.phase12_enable && !drive.phase3_enable && !drive.low_side_discharge)
    else $error("phases active with current limit latched");

  // upward ramp: counters held clear and the latch cannot rise
  a_ramp_up_mask: assert property (@(posedge mclk) disable iff (rst)
    ramping_up |=> cur_ff.oc_cnt == '0 && !$rose(current_limit_latched))
    else $error("over-current counted while ramping up");

  // turn-on low while regulating enters the latched fault, drivers off
  a_enable_low_off: assert property (@(posedge mclk) disable iff (rst)
    cur_ff.st inside {ST_SOFT, ST_RUN} && !p.turn_on_input && supplies_ok |=> cur_ff.st == ST_FAULT ##1 !drive.phase12_enable)
    else $error("turn-on low did not latch drivers off");

  // over-voltage clamps through the low sides one edge later
  a_ov_discharge: assert property (@(posedge mclk) disable iff (rst)
    s_ov_seen |=> s_ov_clamp)
    else $error("over-voltage discharge not entered");

  // under-voltage watch arms only in run with output good
  a_uv_arm_cond: assert property (@(posedge mclk) disable iff (rst)
    $rose(undervoltage_armed) |-> $past(cur_ff.st) == ST_RUN && $past(p.output_good_flag))
    else $error("under-voltage armed early");

  // a shutdown code keeps the idle regulator from starting
  a_shutdown_holds_off: assert property (@(posedge mclk) disable iff (rst)
    cur_ff.st == ST_IDLE && shutdown_code |=> cur_ff.st != ST_SOFT)
    else $error("shutdown code started the regulator");
endmodule
`default_nettype wire

// file: dv/vid_host_model.sv
/*
  host side model: drives the five-bit voltage select code.
  assumes the same mclk as the sequencer; requests arrive from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module vid_host_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // requested and driven code
  input wire logic [4:0] req_code,
  output logic [4:0] voltage_select_code
);
  // parks on a shutdown code out of reset, so nothing ramps before the host speaks
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      voltage_select_code <= 5'h1f;
    end else begin
      voltage_select_code <= req_code;
    end
  end
endmodule
`default_nettype wire

// file: dv/test_core_supply_vid_fault_sequencer.sv
/*
  self-checking bench for the core supply sequencer.
  assumes vid_host_model drives the code; slew is set to 0 for short ramps.
*/
`timescale 1ns/1ps
`default_nettype none
module test_core_supply_vid_fault_sequencer;
  import core_supply_pkg::*;
  logic mclk, rst, ph1_low_on, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  logic [11:0] ref_mv;
  logic [4:0] req_code, host_code, cur;
  logic latched, uv_armed;
  pins_t pins_drv, pins_in;
  drive_t drive;
  int mismatches, compares;

  // host owns the code field, bench owns the rest
  always_comb begin
    pins_in = pins_drv;
    pins_in.voltage_select_code = host_code;
  end

  vid_host_model i_vid_host_model (.mclk(mclk), .rst(rst), .req_code(req_code), .voltage_select_code(host_code));
  core_supply_vid_fault_sequencer i_core_supply_vid_fault_sequencer (.mclk(mclk), .rst(rst), .pins_async(pins_in),
    .ph1_low_on(ph1_low_on), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reference_ramp_node(ref_mv), .drive(drive), .current_limit_latched(latched),
    .undervoltage_armed(uv_armed));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // bound ran out: count it and stop
  task give_up();
    mismatches++;
    $display("MISMATCH wait_bound expected done seen stuck");
    results();
  endtask

  // setpoint in mV from the code bands
  function logic [11:0] mv(input logic [4:0] c);
    mv = c[4] ? LOW_BAND_TOP_MV - LOW_BAND_STEP_MV * {8'h00, c[3:0]}
              : HIGH_BAND_TOP_MV - HIGH_BAND_STEP_MV * {8'h00, c[3:0]};
  endfunction

  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the read edge
  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    rv = reg_rdata;
  endtask

  // waits for run; reference must already sit on target by then
  task bring_up(input logic [4:0] c);
    int n;
    req_code <= c;
    cur = c;
    for (n = 0; n < 12000 && drive.phase3_enable !== 1'b1; n++) @(posedge mclk);
    if (n == 12000) give_up();
    chk("ref_at_run", 16'(ref_mv), 16'(mv(c)));
  endtask

  // follows the ramp, counting any move larger than one step
  task wait_ref(input logic [4:0] c, input logic [11:0] exp);
    int n, jumps;
    logic [11:0] prev;
    req_code <= c;
    prev = ref_mv;
    jumps = 0;
    for (n = 0; n < 12000 && ref_mv !== exp; n++) begin
      @(posedge mclk);
      if (ref_mv - prev > 12'h001 && prev - ref_mv > 12'h001) jumps++;
      prev = ref_mv;
    end
    if (n == 12000) give_up();
    chk("ramp_jumps", 16'(jumps), 16'h0000);
  endtask

  // enable low then high clears the latch; gates drop, the oscillator keeps running
  task recover();
    pins_drv.turn_on_input <= 1'b0;
    tick(8);
    chk("off_drive", 16'(drive), 16'h0008);
    pins_drv.turn_on_input <= 1'b1;
    tick(8);
    chk("latch_clear", 16'(latched), 16'h0000);
    bring_up(cur);
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task t_reset();
    tick(20);
    chk("drive_lockout", 16'(drive), 16'h0000);
    chk("ref_lockout", 16'(ref_mv), 16'h0000);
    rd(SLEW_OFFSET);
    chk("slew_reset", rv, SLEW_RESET);
    rd(8'h0c);
    chk("unmapped", rv, 16'h0000);
    wr(REF_OFFSET, 16'h0123);
    rd(REF_OFFSET);
    chk("ref_ro", rv, 16'h0000);
    wr(SLEW_OFFSET, 16'h0000);
    rd(SLEW_OFFSET);
    chk("slew_rw", rv, 16'h0000);
    $display("test reset done");
  endtask

  task t_soft();
    pins_drv.vcc_above_lockout <= 1'b1;
    pins_drv.vin_above_lockout <= 1'b1;
    tick(200);
    chk("soft_drive", 16'(drive), 16'h000c);
    chk("soft_ramp", 16'(ref_mv > 12'h000 && ref_mv < 12'h514), 16'h0001);
    bring_up(5'h0e);
    chk("uv_nogood", 16'(uv_armed), 16'h0000);
    pins_drv.output_good_flag <= 1'b1;
    tick(8);
    chk("uv_armed", 16'(uv_armed), 16'h0001);
    $display("test soft done");
  endtask

  task t_codes();
    int i;
    for (i = 0; i < 31; i++) begin
      if (i != 15) wait_ref(5'(i), mv(5'(i)));
    end
    for (i = 0; i < 2; i++) begin
      wait_ref(i ? 5'h1f : 5'h0f, 12'h000);
      tick(8);
      chk("shut_drive", 16'(drive), 16'h0008);
      bring_up(5'h0e);
    end
    $display("test codes done");
  endtask

  task t_oc();
    pins_drv.oc_phase3 <= 1'b1;
    tick(70);
    pins_drv.oc_phase3 <= 1'b0;
    tick(10);
    chk("oc_short", 16'(latched), 16'h0000);
    pins_drv.oc_phase3 <= 1'b1;
    tick(76);
    chk("oc_early", 16'(latched), 16'h0000);
    tick(20);
    chk("oc_set", 16'(latched), 16'h0001);
    chk("oc_drive", 16'(drive), 16'h0008);
    pins_drv.oc_phase3 <= 1'b0;
    rd(STATUS_OFFSET);
    chk("status_oc", 16'(rv[7]), 16'h0001);
    recover();
    pins_drv.oc_phase1 <= 1'b1;
    tick(200);
    chk("ph1_gated", 16'(latched), 16'h0000);
    ph1_low_on <= 1'b1;
    tick(150);
    chk("ph1_early", 16'(latched), 16'h0000);
    tick(40);
    chk("ph1_set", 16'(latched), 16'h0001);
    pins_drv.oc_phase1 <= 1'b0;
    pins_drv.vin_above_lockout <= 1'b0;
    tick(8);
    chk("pwr_drive", 16'(drive), 16'h0000);
    pins_drv.vin_above_lockout <= 1'b1;
    tick(8);
    chk("pwr_clear", 16'(latched), 16'h0000);
    bring_up(cur);
    $display("test overcurrent done");
  endtask

  task t_mask();
    wr(SLEW_OFFSET, 16'h000a);
    req_code <= 5'h00;
    tick(20);
    pins_drv.oc_phase3 <= 1'b1;
    tick(300);
    chk("oc_masked", 16'(latched), 16'h0000);
    pins_drv.oc_phase3 <= 1'b0;
    wr(SLEW_OFFSET, 16'h0000);
    wait_ref(5'h00, mv(5'h00));
    cur = 5'h00;
    $display("test mask done");
  endtask

  task t_ov();
    pins_drv.over_voltage <= 1'b1;
    tick(8);
    chk("ov_discharge", 16'({drive.phase3_enable, drive.low_side_discharge}), 16'h0001);
    pins_drv.below_085 <= 1'b1;
    tick(8);
    chk("ov_off", 16'(drive), 16'h0008);
    pins_drv.over_voltage <= 1'b0;
    pins_drv.below_085 <= 1'b0;
    recover();
    $display("test overvoltage done");
  endtask

  // armed watch trips like the other latched faults; then turn-on low from run
  task t_uv();
    tick(2);
    chk("uv_ready", 16'(uv_armed), 16'h0001);
    pins_drv.under_voltage <= 1'b1;
    tick(8);
    chk("uv_drive", 16'(drive), 16'h0008);
    pins_drv.under_voltage <= 1'b0;
    recover();
    recover();
    $display("test undervoltage done");
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    pins_drv = '0;
    pins_drv.turn_on_input = 1'b1;
    ph1_low_on = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    req_code = 5'h0e;
    cur = 5'h0e;
    mismatches = 0;
    compares = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_soft();
    t_codes();
    t_oc();
    t_mask();
    t_ov();
    t_uv();
    results();
  end
endmodule
`default_nettype wire
